// ---- verilog/mpusf_pkg.sv ----
/*
  Package for the core special function register bank: register
  addresses, reset values, status word field positions, pin masks and
  the packed structs carried on the module ports.
  Assumes a single core clock and direct 8-bit register addressing.
*/
package mpusf_pkg;

  // Addresses of the registers held in the main bank
  localparam logic [7:0] A_PORT0 = 8'h80;
  localparam logic [7:0] A_SP = 8'h81;
  localparam logic [7:0] A_DPL0 = 8'h82;
  localparam logic [7:0] A_DPH0 = 8'h83;
  localparam logic [7:0] A_DATA_POINTER1_LOW = 8'h84;
  localparam logic [7:0] A_DATA_POINTER1_HIGH = 8'h85;
  localparam logic [7:0] A_STRETCH = 8'h8E;
  localparam logic [7:0] A_PORT1 = 8'h90;
  localparam logic [7:0] A_PORT1_DIRECTION = 8'h91;
  localparam logic [7:0] A_PSEL = 8'h92;
  localparam logic [7:0] A_PORT2 = 8'hA0;
  localparam logic [7:0] A_PORT2_DIRECTION = 8'hA1;
  localparam logic [7:0] A_PORT0_DIRECTION = 8'hA2;
  localparam logic [7:0] A_MOVX_PAGE = 8'hBF;
  localparam logic [7:0] A_PSW = 8'hD0;
  localparam logic [7:0] A_SUM = 8'hE0;
  localparam logic [7:0] A_HELPER = 8'hF0;

  // Reset values of the main bank
  localparam logic [7:0] R_PORT0 = 8'hFF;
  localparam logic [7:0] R_PORT1 = 8'hFF;
  localparam logic [7:0] R_PORT2 = 8'h00;
  localparam logic [7:0] R_DIR = 8'h00;
  localparam logic [7:0] R_SP = 8'h07;
  localparam logic [7:0] R_STRETCH = 8'h01;
  localparam logic [7:0] R_ZERO = 8'h00;
  localparam logic [15:0] R_PC = 16'h0000;

  // Status word bit positions
  localparam int PSW_CARRY = 7;
  localparam int PSW_HALF = 6;
  localparam int PSW_USER0 = 5;
  localparam int PSW_BANK_HI = 4;
  localparam int PSW_BANK_LO = 3;
  localparam int PSW_WRAP = 2;
  localparam int PSW_USER1 = 1;
  localparam int PSW_PARITY = 0;

  // Bonded pins per port: port bit n drives pin 8*port+n
  localparam logic [7:0] PORT0_PINS = 8'hF0;
  localparam logic [7:0] PORT1_PINS = 8'hCF;
  localparam logic [7:0] PORT2_PINS = 8'h03;

  // Plain storage registers (timers, serial, interrupt control)
  localparam int MISC_N = 24;
  localparam logic [7:0] MISC_ADDR [MISC_N] = '{
    8'h86, 8'h87, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D,
    8'h98, 8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'hA8, 8'hA9,
    8'hAA, 8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hC0, 8'hC8, 8'hD8};
  localparam logic [7:0] MISC_RST [MISC_N] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hD9, 8'h00, 8'h00, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00};
  // Only the top bit of the baud rate control register is kept
  localparam logic [7:0] MISC_MASK [MISC_N] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h80};

  typedef struct packed {
    logic rd;
    logic wr;
    logic bit_op;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mpusf_sfr_req_t;

  typedef struct packed {
    logic upd_carry;
    logic carry;
    logic upd_half;
    logic half;
    logic upd_wrap;
    logic wrap;
  } mpusf_flag_t;

  typedef struct packed {
    logic wr;
    logic [7:0] sum;
    logic [7:0] helper;
  } mpusf_muldiv_t;

  typedef struct packed {
    logic [7:0] port0;
    logic [7:0] port1;
    logic [7:0] port2;
  } mpusf_port_t;

endpackage : mpusf_pkg

// ---- verilog/mpusf_misc_regs.sv ----
/*
  Plain byte storage for the timer, serial and interrupt registers that
  this bank only holds. Read data is combinational from the address.
  Assumes the caller resolves bit accesses into whole-byte writes.
*/
module mpusf_misc_regs #(
  parameter int N = mpusf_pkg::MISC_N
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Access
  input wire logic wr_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic hit_out,
  output logic [7:0] rdata_out
);

  typedef struct packed {
    logic [N-1:0][7:0] regs;
  } mpusf_misc_state_t;

  mpusf_misc_state_t st_ff;
  mpusf_misc_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    hit_out = 1'h0;
    rdata_out = 8'h00;
    for (int i = 0; i < N; i++) begin
      if (addr_in == mpusf_pkg::MISC_ADDR[i]) begin
        hit_out = 1'h1;
        rdata_out = st_ff.regs[i];
        if (wr_en_in) begin
          nxt_st.regs[i] = wdata_in & mpusf_pkg::MISC_MASK[i];
        end
      end
    end
    if (rst_in) begin
      for (int i = 0; i < N; i++) begin
        nxt_st.regs[i] = mpusf_pkg::MISC_RST[i];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    st_ff <= nxt_st;
  end

endmodule : mpusf_misc_regs

// ---- verilog/mpusf_core_regs.sv ----
/*
  Core special function register bank: ports, direction, stack and
  data pointers, program counter, status word, sum and helper
  registers, plus plain storage for the remaining generic registers.
  Assumes the core issues at most one register access per cycle and
  that pins are synchronous to the core clock.
*/
// Contract
// - Generic registers load listed values at reset
// - Stack pointer resets 07, pre-increments on push
// - Two bank bits pick eight-register group base
// - Status word fixed carry-to-parity bit layout
// - Parity bit always tracks sum register parity
// - Data pointer built from writable low, high
// - Program counter resets zero, advances on fetch
// - Sum and helper serve arithmetic, helper scratch
// - Latch bit one drives pin high, zero low
// - Direction bit one output, zero input
// - Three ports map to fixed pin groups
// - Every pin has latch, driver, input buffer
// - Port read returns pin even when output
// - Movx page register supplies upper address byte
// - Stretch control resets to one
// - Baud rate control keeps only top bit
// - Interrupt polarity register resets to zero
// - Pointer select bit zero picks active pointer
// - Unimplemented addresses: writes do nothing
// - Addresses multiple of eight allow bit access
module mpusf_core_regs (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Register access from the core
  input wire mpusf_pkg::mpusf_sfr_req_t sfr_req_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_rbit_out,
  // Hardware updates from the core
  input wire mpusf_pkg::mpusf_flag_t flag_in,
  input wire mpusf_pkg::mpusf_muldiv_t muldiv_in,
  input wire logic sp_push_in,
  input wire logic sp_pop_in,
  input wire logic pc_fetch_in,
  input wire logic pc_load_in,
  input wire logic [15:0] pc_target_in,
  // State seen by the core
  output logic [7:0] sum_out,
  output logic [7:0] helper_out,
  output logic [7:0] psw_out,
  output logic [7:0] stack_pointer_out,
  output logic [15:0] program_counter_out,
  output logic [15:0] data_pointer_out,
  output logic [7:0] bank_base_out,
  output logic [7:0] movx_page_out,
  output logic [2:0] stretch_out,
  // General I/O pins
  input wire mpusf_pkg::mpusf_port_t pin_in,
  output mpusf_pkg::mpusf_port_t pin_out,
  output mpusf_pkg::mpusf_port_t pin_oe_out
);

  typedef struct packed {
    mpusf_pkg::mpusf_port_t latch;
    mpusf_pkg::mpusf_port_t dir;
    mpusf_pkg::mpusf_port_t drive;
    mpusf_pkg::mpusf_port_t oe;
    logic [7:0] sp;
    logic [7:0] dpl0;
    logic [7:0] dph0;
    logic [7:0] data_pointer1_low;
    logic [7:0] data_pointer1_high;
    logic psel;
    logic [7:0] stretch;
    logic [7:0] movx_page;
    logic [7:0] program_status_word;
    logic [7:0] sum;
    logic [7:0] helper;
    logic [15:0] pc;
    logic [15:0] data_pointer_act;
    logic [7:0] bank_base;
    logic [7:0] rdata;
    logic rbit;
  } mpusf_core_state_t;

  mpusf_core_state_t st_ff;
  mpusf_core_state_t nxt_st;

  logic [7:0] byte_addr;
  logic [2:0] bit_idx;
  logic [7:0] latch_view;
  logic [7:0] read_view;
  logic main_hit;
  logic [7:0] wdata_eff;
  logic misc_wr;
  logic misc_hit;
  logic [7:0] misc_rdata;
  logic sp_written;
  logic [7:0] psw_wr;

  // Bonded bits show the pin, unbonded bits the latch
  function automatic logic [7:0] pin_mix(input logic [7:0] pins,
                                         input logic [7:0] latch,
                                         input logic [7:0] mask);
    pin_mix = (pins & mask) | (latch & ~mask);
  endfunction : pin_mix

  // Bit addresses land only on bytes whose address is a multiple of 8
  assign byte_addr = sfr_req_in.bit_op ?
                     {sfr_req_in.addr[7:3], 3'h0} : sfr_req_in.addr;
  assign bit_idx = sfr_req_in.addr[2:0];

  mpusf_misc_regs #(
    .N(mpusf_pkg::MISC_N)
  ) u_misc (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .wr_en_in(misc_wr),
    .addr_in(byte_addr),
    .wdata_in(wdata_eff),
    .hit_out(misc_hit),
    .rdata_out(misc_rdata)
  );

  // Read side: latch view feeds read-modify-write, read view feeds core
  always_comb begin
    main_hit = 1'h1;
    latch_view = 8'h00;
    read_view = 8'h00;
    case (byte_addr)
      mpusf_pkg::A_PORT0: begin
        latch_view = st_ff.latch.port0;
        read_view = pin_mix(pin_in.port0, st_ff.latch.port0,
                            mpusf_pkg::PORT0_PINS);
      end
      mpusf_pkg::A_PORT1: begin
        latch_view = st_ff.latch.port1;
        read_view = pin_mix(pin_in.port1, st_ff.latch.port1,
                            mpusf_pkg::PORT1_PINS);
      end
      mpusf_pkg::A_PORT2: begin
        latch_view = st_ff.latch.port2;
        read_view = pin_mix(pin_in.port2, st_ff.latch.port2,
                            mpusf_pkg::PORT2_PINS);
      end
      mpusf_pkg::A_PORT0_DIRECTION: begin
        latch_view = st_ff.dir.port0;
        read_view = latch_view;
      end
      mpusf_pkg::A_PORT1_DIRECTION: begin
        latch_view = st_ff.dir.port1;
        read_view = latch_view;
      end
      mpusf_pkg::A_PORT2_DIRECTION: begin
        latch_view = st_ff.dir.port2;
        read_view = latch_view;
      end
      mpusf_pkg::A_SP: begin
        latch_view = st_ff.sp;
        read_view = latch_view;
      end
      mpusf_pkg::A_DPL0: begin
        latch_view = st_ff.dpl0;
        read_view = latch_view;
      end
      mpusf_pkg::A_DPH0: begin
        latch_view = st_ff.dph0;
        read_view = latch_view;
      end
      mpusf_pkg::A_DATA_POINTER1_LOW: begin
        latch_view = st_ff.data_pointer1_low;
        read_view = latch_view;
      end
      mpusf_pkg::A_DATA_POINTER1_HIGH: begin
        latch_view = st_ff.data_pointer1_high;
        read_view = latch_view;
      end
      mpusf_pkg::A_PSEL: begin
        latch_view = {7'h00, st_ff.psel};
        read_view = latch_view;
      end
      mpusf_pkg::A_STRETCH: begin
        latch_view = st_ff.stretch;
        read_view = latch_view;
      end
      mpusf_pkg::A_MOVX_PAGE: begin
        latch_view = st_ff.movx_page;
        read_view = latch_view;
      end
      mpusf_pkg::A_PSW: begin
        latch_view = st_ff.program_status_word;
        read_view = latch_view;
      end
      mpusf_pkg::A_SUM: begin
        latch_view = st_ff.sum;
        read_view = latch_view;
      end
      mpusf_pkg::A_HELPER: begin
        latch_view = st_ff.helper;
        read_view = latch_view;
      end
      default: begin
        main_hit = 1'h0;
        // Unmapped addresses read as zero
        latch_view = misc_hit ? misc_rdata : 8'h00;
        read_view = latch_view;
      end
    endcase
  end

  // Bit writes merge one bit into the current latch contents
  always_comb begin
    wdata_eff = sfr_req_in.wdata;
    if (sfr_req_in.bit_op) begin
      wdata_eff = latch_view;
      wdata_eff[bit_idx] = sfr_req_in.wdata[0];
    end
  end

  // Misc store ignores addresses it does not hold
  assign misc_wr = sfr_req_in.wr & ~main_hit;
  assign sp_written = sfr_req_in.wr && (byte_addr == mpusf_pkg::A_SP);

  always_comb begin
    nxt_st = st_ff;
    psw_wr = st_ff.program_status_word;
    if (sfr_req_in.wr) begin
      case (byte_addr)
        mpusf_pkg::A_PORT0: nxt_st.latch.port0 = wdata_eff;
        mpusf_pkg::A_PORT1: nxt_st.latch.port1 = wdata_eff;
        mpusf_pkg::A_PORT2: nxt_st.latch.port2 = wdata_eff;
        mpusf_pkg::A_PORT0_DIRECTION: nxt_st.dir.port0 = wdata_eff;
        mpusf_pkg::A_PORT1_DIRECTION: nxt_st.dir.port1 = wdata_eff;
        mpusf_pkg::A_PORT2_DIRECTION: nxt_st.dir.port2 = wdata_eff;
        mpusf_pkg::A_SP: nxt_st.sp = wdata_eff;
        mpusf_pkg::A_DPL0: nxt_st.dpl0 = wdata_eff;
        mpusf_pkg::A_DPH0: nxt_st.dph0 = wdata_eff;
        mpusf_pkg::A_DATA_POINTER1_LOW: nxt_st.data_pointer1_low = wdata_eff;
        mpusf_pkg::A_DATA_POINTER1_HIGH: nxt_st.data_pointer1_high = wdata_eff;
        mpusf_pkg::A_PSEL: nxt_st.psel = wdata_eff[0];
        mpusf_pkg::A_STRETCH: nxt_st.stretch = wdata_eff;
        mpusf_pkg::A_MOVX_PAGE: nxt_st.movx_page = wdata_eff;
        mpusf_pkg::A_PSW: psw_wr = wdata_eff;
        mpusf_pkg::A_SUM: nxt_st.sum = wdata_eff;
        mpusf_pkg::A_HELPER: nxt_st.helper = wdata_eff;
        default: begin
        end
      endcase
    end

    // Software write to the pointer beats a push or pop in that cycle
    if (!sp_written) begin
      if (sp_push_in && !sp_pop_in) begin
        nxt_st.sp = st_ff.sp + 8'h01;
      end else if (sp_pop_in && !sp_push_in) begin
        nxt_st.sp = st_ff.sp - 8'h01;
      end
    end

    if (pc_load_in) begin
      nxt_st.pc = pc_target_in;
    end else if (pc_fetch_in) begin
      nxt_st.pc = st_ff.pc + 16'h0001;
    end

    // Instruction results override a same-cycle software flag write
    if (flag_in.upd_carry) begin
      psw_wr[mpusf_pkg::PSW_CARRY] = flag_in.carry;
    end
    if (flag_in.upd_half) begin
      psw_wr[mpusf_pkg::PSW_HALF] = flag_in.half;
    end
    if (flag_in.upd_wrap) begin
      psw_wr[mpusf_pkg::PSW_WRAP] = flag_in.wrap;
    end

    if (muldiv_in.wr) begin
      nxt_st.sum = muldiv_in.sum;
      nxt_st.helper = muldiv_in.helper;
    end

    // Parity is never software-writable; it follows the next sum value
    nxt_st.program_status_word = psw_wr;
    nxt_st.program_status_word[mpusf_pkg::PSW_PARITY] = ^nxt_st.sum;

    if (sfr_req_in.rd) begin
      nxt_st.rdata = read_view;
      nxt_st.rbit = read_view[bit_idx];
    end

    if (rst_in) begin
      nxt_st.latch.port0 = mpusf_pkg::R_PORT0;
      nxt_st.latch.port1 = mpusf_pkg::R_PORT1;
      nxt_st.latch.port2 = mpusf_pkg::R_PORT2;
      nxt_st.dir.port0 = mpusf_pkg::R_DIR;
      nxt_st.dir.port1 = mpusf_pkg::R_DIR;
      nxt_st.dir.port2 = mpusf_pkg::R_DIR;
      nxt_st.sp = mpusf_pkg::R_SP;
      nxt_st.dpl0 = mpusf_pkg::R_ZERO;
      nxt_st.dph0 = mpusf_pkg::R_ZERO;
      nxt_st.data_pointer1_low = mpusf_pkg::R_ZERO;
      nxt_st.data_pointer1_high = mpusf_pkg::R_ZERO;
      nxt_st.psel = 1'h0;
      nxt_st.stretch = mpusf_pkg::R_STRETCH;
      nxt_st.movx_page = mpusf_pkg::R_ZERO;
      nxt_st.program_status_word = mpusf_pkg::R_ZERO;
      nxt_st.sum = mpusf_pkg::R_ZERO;
      nxt_st.helper = mpusf_pkg::R_ZERO;
      nxt_st.pc = mpusf_pkg::R_PC;
      nxt_st.rdata = mpusf_pkg::R_ZERO;
      nxt_st.rbit = 1'h0;
    end

    // Registered copies so every output leaves a flip-flop
    nxt_st.data_pointer_act = nxt_st.psel ? {nxt_st.data_pointer1_high, nxt_st.data_pointer1_low}
                                  : {nxt_st.dph0, nxt_st.dpl0};
    nxt_st.bank_base = {3'h0, nxt_st.program_status_word[mpusf_pkg::PSW_BANK_HI],
                        nxt_st.program_status_word[mpusf_pkg::PSW_BANK_LO], 3'h0};
    nxt_st.drive = nxt_st.latch;
    nxt_st.oe.port0 = nxt_st.dir.port0 &
                      mpusf_pkg::PORT0_PINS;
    nxt_st.oe.port1 = nxt_st.dir.port1 &
                      mpusf_pkg::PORT1_PINS;
    nxt_st.oe.port2 = nxt_st.dir.port2 &
                      mpusf_pkg::PORT2_PINS;
  end

  always_ff @(posedge ref_clk_in) begin
    st_ff <= nxt_st;
  end

  assign sfr_rdata_out = st_ff.rdata;
  assign sfr_rbit_out = st_ff.rbit;
  assign sum_out = st_ff.sum;
  assign helper_out = st_ff.helper;
  assign psw_out = st_ff.program_status_word;
  assign stack_pointer_out = st_ff.sp;
  assign program_counter_out = st_ff.pc;
  assign data_pointer_out = st_ff.data_pointer_act;
  assign bank_base_out = st_ff.bank_base;
  assign movx_page_out = st_ff.movx_page;
  assign stretch_out = st_ff.stretch[2:0];
  assign pin_out = st_ff.drive;
  assign pin_oe_out = st_ff.oe;

endmodule : mpusf_core_regs

// ---- bench/mpusf_core_regs_checker.sv ----
/*
  Port-level assertions for the core register bank.
  Assumes it is bound to mpusf_core_regs and sees only its ports.
*/
module mpusf_core_regs_checker (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Requests
  input wire mpusf_pkg::mpusf_sfr_req_t sfr_req_in,
  input wire logic sp_push_in,
  input wire logic sp_pop_in,
  input wire logic pc_fetch_in,
  input wire logic pc_load_in,
  // Observed state
  input wire logic [7:0] sfr_rdata_out,
  input wire logic [7:0] sum_out,
  input wire logic [7:0] psw_out,
  input wire logic [7:0] stack_pointer_out,
  input wire logic [15:0] program_counter_out,
  input wire logic [7:0] bank_base_out,
  input wire mpusf_pkg::mpusf_port_t pin_in,
  input wire mpusf_pkg::mpusf_port_t pin_out,
  input wire mpusf_pkg::mpusf_port_t pin_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // A software write to the stack pointer overrides push and pop
  wire logic sp_wr = sfr_req_in.wr && !sfr_req_in.bit_op &&
                     sfr_req_in.addr == 8'h81;

  sequence s_bwr(a);
    sfr_req_in.wr && !sfr_req_in.bit_op && sfr_req_in.addr == a;
  endsequence
  sequence s_brd(a);
    sfr_req_in.rd && !sfr_req_in.bit_op && sfr_req_in.addr == a;
  endsequence

  a_reset_load:
    assert property (disable iff (1'h0) rst_in |=>
      stack_pointer_out == 8'h07 && program_counter_out == 16'h0000 &&
      pin_out.port0 == 8'hFF && pin_oe_out == '0)
    else $error("reset values not loaded");
  a_sp_push:
    assert property (sp_push_in && !sp_pop_in && !sp_wr |=>
      stack_pointer_out == $past(stack_pointer_out) + 8'h01)
    else $error("stack pointer did not advance on push");
  a_pc_fetch:
    assert property (pc_fetch_in && !pc_load_in |=>
      program_counter_out == $past(program_counter_out) + 16'h0001)
    else $error("program counter did not advance on fetch");
  a_parity_track:
    assert property (psw_out[0] == ^sum_out)
    else $error("parity bit does not match sum register");
  a_bank_base:
    assert property (bank_base_out == {3'h0, psw_out[4:3], 3'h0})
    else $error("bank base does not follow bank select");
  a_dir_enable:
    assert property (s_bwr(8'hA2) |=>
      pin_oe_out.port0 == ($past(sfr_req_in.wdata) & 8'hF0))
    else $error("port 0 enables do not follow direction");
  a_latch_pin:
    assert property (s_bwr(8'h90) |=>
      pin_out.port1 == $past(sfr_req_in.wdata))
    else $error("port 1 drive does not follow latch");
  a_port_read:
    assert property (s_brd(8'h80) |=> sfr_rdata_out ==
      (($past(pin_in.port0) & 8'hF0) | ($past(pin_out.port0) & 8'h0F)))
    else $error("port 0 read does not show pins");
  a_read_hold:
    assert property (!sfr_req_in.rd |=> $stable(sfr_rdata_out))
    else $error("read data changed without a read");
endmodule : mpusf_core_regs_checker

// ---- bench/mpusf_pin_model.sv ----
/*
  External circuitry on the general I/O pins.
  Assumes pins settle within one core clock.
*/
module mpusf_pin_model (
  // From the bank
  input wire mpusf_pkg::mpusf_port_t drv_in,
  input wire mpusf_pkg::mpusf_port_t oe_in,
  // External levels and a sink that can override a driven pin
  input wire mpusf_pkg::mpusf_port_t ext_in,
  input wire mpusf_pkg::mpusf_port_t clamp_in,
  // Resolved pin levels
  output mpusf_pkg::mpusf_port_t level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Another engine may sink a driven pin, so read-back can differ
  assign level_out = ((drv_in & oe_in) | (ext_in & ~oe_in)) & ~clamp_in;
endmodule : mpusf_pin_model

// ---- bench/tb_top.sv ----
/*
  Testbench for the core register bank: register access tasks and
  directed tests. Assumes a pin model on the far side of the ports.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  mpusf_pkg::mpusf_sfr_req_t req = '0;
  mpusf_pkg::mpusf_flag_t flag = '0;
  mpusf_pkg::mpusf_muldiv_t md = '0;
  logic push = 1'b0, pop = 1'b0, fetch = 1'b0, load = 1'b0;
  logic [15:0] target = 16'h0000;
  logic [7:0] rdata, sum, helper, program_status_word, sp, bbase, page;
  logic rbit;
  logic [2:0] stretch;
  logic [15:0] pc, data_pointer;
  mpusf_pkg::mpusf_port_t pins, drv, oe;
  mpusf_pkg::mpusf_port_t ext = {8'hC3, 8'h96, 8'h02};
  mpusf_pkg::mpusf_port_t clamp = '0;
  int n_fail = 0, cmp_count = 0;

  always #10 ref_clk_in = ~ref_clk_in;

  mpusf_core_regs u_mpusf_core_regs (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .sfr_req_in(req),
    .sfr_rdata_out(rdata), .sfr_rbit_out(rbit), .flag_in(flag),
    .muldiv_in(md), .sp_push_in(push), .sp_pop_in(pop),
    .pc_fetch_in(fetch), .pc_load_in(load), .pc_target_in(target),
    .sum_out(sum), .helper_out(helper), .psw_out(program_status_word),
    .stack_pointer_out(sp), .program_counter_out(pc),
    .data_pointer_out(data_pointer), .bank_base_out(bbase),
    .movx_page_out(page), .stretch_out(stretch), .pin_in(pins),
    .pin_out(drv), .pin_oe_out(oe));

  mpusf_pin_model u_mpusf_pin_model (
    .drv_in(drv), .oe_in(oe), .ext_in(ext), .clamp_in(clamp),
    .level_out(pins));

  task automatic summarize();
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk16({8'h00, got}, {8'h00, exp});
  endtask : chk8

  task automatic wr(input logic bop, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge ref_clk_in);
    req <= '{rd: 1'b0, wr: 1'b1, bit_op: bop, addr: a, wdata: d};
    @(posedge ref_clk_in);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic bop, input logic [7:0] a,
                        input logic [7:0] exp);
    @(posedge ref_clk_in);
    req <= '{rd: 1'b1, wr: 1'b0, bit_op: bop, addr: a, wdata: 8'h00};
    @(posedge ref_clk_in);
    req.rd <= 1'b0;
    @(negedge ref_clk_in);
    chk8(bop ? {7'h00, rbit} : rdata, exp);
  endtask : rd_chk

  function automatic logic [7:0] rst_val(input logic [7:0] a);
    case (a)
      8'h80, 8'h90: return 8'hFF;
      8'h81: return 8'h07;
      8'h8E: return 8'h01;
      8'hAA: return 8'hD9;
      8'hBA, 8'hBB: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction : rst_val

  // Unmapped reads were chosen to return zero
  function automatic logic [7:0] rd_val(input logic [7:0] a,
                                        input logic [7:0] v);
    if (!(a inside {[8'h80:8'h8E], [8'h90:8'h92], [8'h98:8'h9D],
        [8'hA0:8'hA2], [8'hA8:8'hAA], [8'hB8:8'hBB], 8'hBF, 8'hC0,
        8'hC8, 8'hD0, 8'hD8, 8'hE0, 8'hF0}))
      return 8'h00;
    case (a)
      8'h80: return (ext.port0 & 8'hF0) | (v & 8'h0F);
      8'h90: return (ext.port1 & 8'hCF) | (v & 8'h30);
      8'hA0: return (ext.port2 & 8'h03) | (v & 8'hFC);
      8'h92: return v & 8'h01;
      8'hD0: return v & 8'hFE;
      8'hD8: return v & 8'h80;
      default: return v;
    endcase
  endfunction : rd_val

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_fail++;
    summarize();
  end

  initial begin
    logic [7:0] a;
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'h0;
    @(negedge ref_clk_in);
    chk16(pc, 16'h0000);
    chk8(oe.port0 | oe.port1 | oe.port2, 8'h00);
    chk8({5'h00, stretch}, 8'h01);
    for (int i = 128; i < 256; i++) begin
      a = i[7:0];
      rd_chk(1'h0, a, rd_val(a, rst_val(a)));
    end
    @(posedge ref_clk_in);
    push <= 1'h1;
    @(posedge ref_clk_in);
    push <= 1'h0;
    @(negedge ref_clk_in);
    chk8(sp, 8'h08);
    // Push and pop together cancel, then a lone pop steps back
    @(posedge ref_clk_in);
    push <= 1'h1;
    pop <= 1'h1;
    @(posedge ref_clk_in);
    push <= 1'h0;
    @(posedge ref_clk_in);
    pop <= 1'h0;
    @(negedge ref_clk_in);
    chk8(sp, 8'h07);
    @(posedge ref_clk_in);
    fetch <= 1'h1;
    repeat (3) @(posedge ref_clk_in);
    fetch <= 1'h0;
    @(negedge ref_clk_in);
    chk16(pc, 16'h0003);
    @(posedge ref_clk_in);
    load <= 1'h1;
    fetch <= 1'h1;
    target <= 16'hFFFF;
    @(posedge ref_clk_in);
    load <= 1'h0;
    @(posedge ref_clk_in);
    fetch <= 1'h0;
    @(negedge ref_clk_in);
    chk16(pc, 16'h0000);
    for (int i = 128; i < 256; i++) begin
      a = i[7:0];
      wr(1'h0, a, a ^ 8'hA5);
      rd_chk(1'h0, a, rd_val(a, a ^ 8'hA5));
    end
    wr(1'h0, 8'hD8, 8'hFF);
    rd_chk(1'h0, 8'hD8, 8'h80);
    wr(1'h0, 8'hA2, 8'hFF);
    wr(1'h0, 8'h80, 8'hA5);
    @(negedge ref_clk_in);
    chk8(drv.port0, 8'hA5);
    chk8(oe.port0, 8'hF0);
    @(posedge ref_clk_in);
    clamp.port0 <= 8'h80;
    rd_chk(1'h0, 8'h80, 8'h25);
    rd_chk(1'h1, 8'h87, 8'h00);
    rd_chk(1'h1, 8'h85, 8'h01);
    wr(1'h1, 8'h80, 8'h00);
    wr(1'h1, 8'h92, 8'h00);
    @(negedge ref_clk_in);
    chk8(drv.port0, 8'hA4);
    chk8(drv.port1, 8'h31);
    wr(1'h0, 8'h82, 8'h11);
    wr(1'h0, 8'h83, 8'h22);
    wr(1'h0, 8'h84, 8'h33);
    wr(1'h0, 8'h85, 8'h44);
    wr(1'h0, 8'h92, 8'h00);
    @(negedge ref_clk_in);
    chk16(data_pointer, 16'h2211);
    wr(1'h0, 8'h92, 8'hFF);
    @(negedge ref_clk_in);
    chk16(data_pointer, 16'h4433);
    for (int j = 0; j < 4; j++) begin
      wr(1'h0, 8'hD0, {3'h0, j[1:0], 3'h0});
      @(negedge ref_clk_in);
      chk8(bbase, {3'h0, j[1:0], 3'h0});
      chk8(program_status_word, {3'h0, j[1:0], 3'h1});
    end
    @(posedge ref_clk_in);
    flag <= '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1};
    md <= '{wr: 1'h1, sum: 8'h12, helper: 8'h34};
    @(posedge ref_clk_in);
    flag <= '0;
    md.wr <= 1'h0;
    @(negedge ref_clk_in);
    chk8(program_status_word, 8'hDC);
    chk8(sum, 8'h12);
    chk8(helper, 8'h34);
    rd_chk(1'h0, 8'hF0, 8'h34);
    wr(1'h0, 8'hBF, 8'h5C);
    @(negedge ref_clk_in);
    chk8(page, 8'h5C);
    @(posedge ref_clk_in);
    rst_in <= 1'h1;
    clamp <= '0;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'h0;
    rd_chk(1'h0, 8'hAA, 8'hD9);
    chk8(drv.port2, 8'h00);
    summarize();
  end
endmodule : tb_top

bind mpusf_core_regs mpusf_core_regs_checker u_mpusf_core_regs_checker (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .sfr_req_in(sfr_req_in),
  .sp_push_in(sp_push_in), .sp_pop_in(sp_pop_in),
  .pc_fetch_in(pc_fetch_in), .pc_load_in(pc_load_in),
  .sfr_rdata_out(sfr_rdata_out), .sum_out(sum_out), .psw_out(psw_out),
  .stack_pointer_out(stack_pointer_out),
  .program_counter_out(program_counter_out),
  .bank_base_out(bank_base_out), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_out(pin_oe_out));
